// ==== rns_store.sv ====
`timescale 1ns/1ps

module rns_store
  import rns_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_DIV,
  parameter int unsigned DEB_TICKS   = STROBE_TICKS,
  parameter int unsigned HOLD_TICKS  = OUT_HOLD_TICKS,
  parameter int unsigned STB_TICKS   = OUT_STB_TICKS
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       reset_n_pin,
  input  wire logic       chip_select,
  input  wire logic       store_mode,
  input  wire logic       recall_mode,
  input  wire logic       strobe_gate,
  input  wire logic       strobe_in_n,
  input  wire logic [3:0] bus_in,
  output logic      [3:0] bus_out,
  output logic            bus_oe_n,
  output logic            strobe_out_n,
  output logic            addr_lock_n,
  output logic            digit_lock_n,
  output logic            recall_locked
);

  // ****************************************************************
  // tick divider and input synchronisers
  // ****************************************************************
  logic [15:0] div_reg;
  logic        tick_reg;
  logic [1:0]  rstn_sync, cs_sync, st_sync, rc_sync, gt_sync, sb_sync;
  logic [3:0]  bus_s1, bus_s2;

  wire div_end = (div_reg >= 16'(TICK_CYCLES - 1));

  // one-cycle tick at the logic rate, all timing counts this
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_end ? 16'h0000 : div_reg + 16'h0001;
      tick_reg <= div_end;
    end
  end

  // pins come from outside, two stages before use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstn_sync <= 2'h0;
      cs_sync   <= 2'h0;
      st_sync   <= 2'h0;
      rc_sync   <= 2'h0;
      gt_sync   <= 2'h0;
      sb_sync   <= 2'h3;
      bus_s1    <= 4'h0;
      bus_s2    <= 4'h0;
    end else begin
      rstn_sync <= {rstn_sync[0], reset_n_pin};
      cs_sync   <= {cs_sync[0], chip_select};
      st_sync   <= {st_sync[0], store_mode};
      rc_sync   <= {rc_sync[0], recall_mode};
      gt_sync   <= {gt_sync[0], strobe_gate};
      sb_sync   <= {sb_sync[0], strobe_in_n};
      bus_s1    <= bus_in;
      bus_s2    <= bus_s1;
    end
  end

  wire cs_s   = cs_sync[1];
  wire gate_s = gt_sync[1];

  // ****************************************************************
  // pin reset filter and input strobe / recall qualification
  // ****************************************************************
  logic rst_deb_n, strobe_deb_n, recall_deb;
  logic strobe_deb_d;

  // external reset counts as accepted only after RESET_TICKS low
  rns_debounce #(.COUNT(RESET_TICKS)) u_rst_deb (
    .clk    (clk),
    .sys_rst(sys_rst),
    .tick   (tick_reg),
    .din    (rstn_sync[1]),
    .init   (1'b0),
    .dout   (rst_deb_n)
  );

  rns_debounce #(.COUNT(DEB_TICKS)) u_stb_deb (
    .clk    (clk),
    .sys_rst(sys_rst),
    .tick   (tick_reg),
    .din    (sb_sync[1] | ~cs_s),
    .init   (1'b1),
    .dout   (strobe_deb_n)
  );

  rns_debounce #(.COUNT(DEB_TICKS)) u_rc_deb (
    .clk    (clk),
    .sys_rst(sys_rst),
    .tick   (tick_reg),
    .din    (rc_sync[1] & cs_s),
    .init   (1'b0),
    .dout   (recall_deb)
  );

  wire logic_rst = sys_rst | ~rst_deb_n;
  wire strobe_hit = strobe_deb_d & ~strobe_deb_n;  // accepted falling edge

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic [3:0] loc_dec;
  logic       loc_valid;

  // fixed code table; anything else is not an address
  always_comb begin
    loc_valid = 1'b1;
    unique case (bus_s2)
      ADDR_1:  loc_dec = 4'h0;
      ADDR_2:  loc_dec = 4'h1;
      ADDR_3:  loc_dec = 4'h2;
      ADDR_4:  loc_dec = 4'h3;
      ADDR_5:  loc_dec = 4'h4;
      ADDR_6:  loc_dec = 4'h5;
      ADDR_7:  loc_dec = 4'h6;
      ADDR_8:  loc_dec = 4'h7;
      ADDR_9:  loc_dec = 4'h8;
      ADDR_10: loc_dec = 4'h9;
      default: begin
        loc_dec   = 4'h0;
        loc_valid = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // digit memory
  // ****************************************************************
  logic [3:0] mem_reg [NUM_LOCS][MAX_DIGITS];
  logic [4:0] len_reg [NUM_LOCS];
  logic [3:0] loc_reg;
  logic [4:0] ptr_reg;
  logic [15:0] tcnt_reg;
  rns_state_t state_reg;

  wire in_store_cmd = cs_s & st_sync[1] & gate_s;
  wire store_go     = (state_reg == RNS_IDLE) & in_store_cmd & strobe_hit & loc_valid;
  wire store_wr     = (state_reg == RNS_STORE) & cs_s & strobe_hit
                      & (len_reg[loc_reg] < 5'(MAX_DIGITS));
  wire recall_go    = (state_reg == RNS_RECALL_WAIT) & cs_s & strobe_hit & loc_valid;
  wire play_last    = (ptr_reg >= len_reg[loc_reg]);

  // storage is not reset: digits survive a reset, only lengths are cleared
  always_ff @(posedge clk) begin
    if (store_wr) begin
      mem_reg[loc_reg][len_reg[loc_reg]] <= bus_s2;
    end
  end

  // lengths cleared at reset, cleared when address opens
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      for (int i = 0; i < NUM_LOCS; i++) begin
        len_reg[i] <= 5'h00;
      end
    end else if (store_go) begin
      len_reg[loc_dec] <= 5'h00;
    end else if (store_wr) begin
      len_reg[loc_reg] <= len_reg[loc_reg] + 5'h01;
    end
  end

  // ****************************************************************
  // control sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    strobe_deb_d <= logic_rst ? 1'b1 : strobe_deb_n;
  end

  // store and recall sequencing, outputs all registered
  always_ff @(posedge clk) begin
    if (logic_rst) begin
      state_reg     <= RNS_IDLE;
      loc_reg       <= 4'h0;
      ptr_reg       <= 5'h00;
      tcnt_reg      <= 16'h0000;
      bus_out       <= 4'h0;
      bus_oe_n      <= 1'b1;
      strobe_out_n  <= 1'b1;
      addr_lock_n   <= 1'b1;
      digit_lock_n  <= 1'b1;
      recall_locked <= 1'b0;
    end else begin
      unique case (state_reg)
        RNS_IDLE: begin
          if (store_go) begin
            loc_reg     <= loc_dec;
            addr_lock_n <= 1'b0;
            state_reg   <= RNS_STORE;
          end else if (recall_deb && !st_sync[1]) begin
            recall_locked <= 1'b1;
            state_reg     <= RNS_RECALL_WAIT;
          end
        end
        RNS_STORE: begin
          // host ends the store by releasing store or select
          if (!(cs_s && st_sync[1])) begin
            addr_lock_n <= 1'b1;
            state_reg   <= RNS_IDLE;
          end
        end
        RNS_RECALL_WAIT: begin
          if (recall_go) begin
            loc_reg      <= loc_dec;
            ptr_reg      <= 5'h00;
            tcnt_reg     <= 16'h0000;
            addr_lock_n  <= 1'b0;
            digit_lock_n <= 1'b0;
            state_reg    <= RNS_PLAY;
          end
        end
        RNS_PLAY: begin
          if (play_last) begin
            bus_oe_n      <= 1'b1;
            addr_lock_n   <= 1'b1;
            digit_lock_n  <= 1'b1;
            recall_locked <= 1'b0;
            state_reg     <= RNS_IDLE;
          end else if (tick_reg) begin
            // digits start on a tick so strobe and hold are whole ticks;
            // bus driven only once both keyboards are locked out
            bus_out      <= mem_reg[loc_reg][ptr_reg];
            bus_oe_n     <= 1'b0;
            strobe_out_n <= 1'b0;
            tcnt_reg     <= 16'h0000;
            state_reg    <= RNS_PLAY_GAP;
          end
        end
        RNS_PLAY_GAP: begin
          if (tick_reg) begin
            tcnt_reg <= tcnt_reg + 16'h0001;
            if (tcnt_reg == 16'(STB_TICKS - 1)) begin
              strobe_out_n <= 1'b1;
            end
            if (tcnt_reg == 16'(HOLD_TICKS - 1)) begin
              ptr_reg   <= ptr_reg + 5'h01;
              state_reg <= RNS_PLAY;
            end
          end
        end
      endcase
      // during a store the gate holds the output strobe off
      if (state_reg == RNS_STORE && gate_s) begin
        strobe_out_n <= 1'b1;
      end
    end
  end

endmodule : rns_store

// ==== rns_pkg.sv ====
package rns_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned TICK_HZ        = 18_000;      // nominal logic clock rate
  localparam int unsigned TICK_DIV       = CLK_HZ / TICK_HZ;
  localparam int unsigned RESET_MS       = 5;
  localparam int unsigned STROBE_MS      = 40;
  // least times round up to whole ticks
  localparam int unsigned RESET_TICKS    = (RESET_MS * TICK_HZ + 999) / 1000;
  localparam int unsigned STROBE_TICKS   = (STROBE_MS * TICK_HZ + 999) / 1000;
  localparam int unsigned OUT_HOLD_TICKS = 900;  // digit hold on the bus
  localparam int unsigned OUT_STB_TICKS  = 360;  // strobe width inside the hold

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int unsigned NUM_LOCS   = 10;
  localparam int unsigned MAX_DIGITS = 22;

  // ****************************************************************
  // address codes, bus bit d0 is the msb of each constant
  // ****************************************************************
  localparam logic [3:0] ADDR_1  = 4'hF;
  localparam logic [3:0] ADDR_2  = 4'hE;
  localparam logic [3:0] ADDR_3  = 4'hD;
  localparam logic [3:0] ADDR_4  = 4'hB;
  localparam logic [3:0] ADDR_5  = 4'hA;
  localparam logic [3:0] ADDR_6  = 4'h9;
  localparam logic [3:0] ADDR_7  = 4'h7;
  localparam logic [3:0] ADDR_8  = 4'h6;
  localparam logic [3:0] ADDR_9  = 4'h5;
  localparam logic [3:0] ADDR_10 = 4'hC;

  typedef enum logic [2:0] {
    RNS_IDLE,
    RNS_STORE,
    RNS_RECALL_WAIT,
    RNS_PLAY,
    RNS_PLAY_GAP
  } rns_state_t;

endpackage : rns_pkg

// ==== rns_debounce.sv ====
`timescale 1ns/1ps

// stable-level filter: out follows in only after COUNT steady ticks
module rns_debounce
  import rns_pkg::*;
#(
  parameter int unsigned COUNT = 720
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic tick,
  input  wire logic din,
  input  wire logic init,
  output logic      dout
);

  logic [15:0] cnt_reg;
  wire         differs = (din != dout);
  wire         done    = (cnt_reg >= 16'(COUNT - 1));

  // restart count on every bounce, so only steady levels pass
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= 16'h0000;
      dout    <= init;
    end else if (!differs) begin
      cnt_reg <= 16'h0000;
    end else if (tick) begin
      if (done) begin
        dout    <= din;
        cnt_reg <= 16'h0000;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

endmodule : rns_debounce

// ==== rns_store_assertions.sv ====
`timescale 1ns/1ps
// ****************
// port checks
// ****************
module rns_store_assertions
  import rns_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       chip_select,
  input wire logic       store_mode,
  input wire logic       strobe_gate,
  input wire logic [3:0] bus_out,
  input wire logic       bus_oe_n,
  input wire logic       strobe_out_n,
  input wire logic       addr_lock_n,
  input wire logic       digit_lock_n,
  input wire logic       recall_locked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // outputs idle once reset lets go
  property p_reset_idle;
    $past(sys_rst) |-> bus_oe_n && strobe_out_n && addr_lock_n && !recall_locked;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_drive_locked;
    !bus_oe_n |-> !digit_lock_n && !addr_lock_n;
  endproperty
  a_drive_locked: assert property (p_drive_locked)
    else $error("bus driven with keyboards enabled");
  property p_gate_mutes;
    store_mode && strobe_gate && digit_lock_n |-> strobe_out_n;
  endproperty
  a_gate_mutes: assert property (p_gate_mutes)
    else $error("output strobe during store");
  property p_strobe_drives;
    !strobe_out_n |-> !bus_oe_n;
  endproperty
  a_strobe_drives: assert property (p_strobe_drives)
    else $error("output strobe without bus drive");
  // digit must not move under the strobe
  property p_bus_steady;
    !strobe_out_n ##1 !strobe_out_n |-> $stable(bus_out);
  endproperty
  a_bus_steady: assert property (p_bus_steady)
    else $error("bus changed under strobe");
  property p_strobe_width;
    $fell(strobe_out_n) |-> (!strobe_out_n) [*7];
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("output strobe too short");
  property p_digit_lock;
    $fell(digit_lock_n) |-> $past(recall_locked);
  endproperty
  a_digit_lock: assert property (p_digit_lock)
    else $error("digit lock outside recall");
  property p_addr_cs;
    $fell(addr_lock_n) |-> $past(chip_select, 3);
  endproperty
  a_addr_cs: assert property (p_addr_cs)
    else $error("address latched without select");
  property p_release;
    $rose(digit_lock_n) |-> addr_lock_n && bus_oe_n && !recall_locked;
  endproperty
  a_release: assert property (p_release)
    else $error("locks not released together");
endmodule : rns_store_assertions

bind rns_store rns_store_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
  .chip_select(chip_select), .store_mode(store_mode), .strobe_gate(strobe_gate),
  .bus_out(bus_out), .bus_oe_n(bus_oe_n), .strobe_out_n(strobe_out_n),
  .addr_lock_n(addr_lock_n), .digit_lock_n(digit_lock_n), .recall_locked(recall_locked));

// ==== rns_far_end.sv ====
`timescale 1ns/1ps
// ****************
// keyboard and dialler
// ****************
module rns_far_end (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic       key_drive,
  input  wire logic [3:0] key_val,
  input  wire logic [3:0] bus_out,
  input  wire logic       bus_oe_n,
  input  wire logic       strobe_out_n,
  output logic      [3:0] bus_in,
  output int              n_got
);
  logic [3:0] last_v = 4'h0;
  logic       stb_d  = 1'b1;
  logic [3:0] got [32];
  // device wins; idle bus toggles so a stale value never looks valid
  assign bus_in = !bus_oe_n ? bus_out : key_drive ? key_val : ~last_v;
  // dialler takes one digit per falling strobe edge
  always @(posedge clk) begin
    last_v <= bus_in;
    stb_d <= strobe_out_n;
    if (clr) n_got <= 0;
    else if (stb_d && !strobe_out_n && n_got < 32) begin
      got[n_got] <= bus_out;
      n_got <= n_got + 1;
    end
  end
endmodule : rns_far_end

// ==== tb_rns_store.sv ====
`timescale 1ns/1ps
module tb_rns_store;
  import rns_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, reset_n_pin = 1'b0, chip_select = 1'b0;
  logic store_mode = 1'b0, recall_mode = 1'b0, strobe_gate = 1'b1;
  logic strobe_in_n = 1'b1, key_drive = 1'b0, clr = 1'b0;
  logic [3:0] key_val = 4'h0;
  wire logic [3:0] bus_in, bus_out;
  wire logic bus_oe_n, strobe_out_n, addr_lock_n, digit_lock_n, recall_locked;
  int n_mismatch = 0, n_compared = 0, n_got;
  logic [3:0] exp_mem [10][$];
  logic [3:0] codes [10] = '{ADDR_1, ADDR_2, ADDR_3, ADDR_4, ADDR_5,
                             ADDR_6, ADDR_7, ADDR_8, ADDR_9, ADDR_10};
  always #5 clk = ~clk;
  // short counts keep the run brief
  rns_store #(.TICK_CYCLES(4), .DEB_TICKS(4), .HOLD_TICKS(6), .STB_TICKS(2)) dut (
    .clk(clk), .sys_rst(sys_rst), .reset_n_pin(reset_n_pin), .chip_select(chip_select),
    .store_mode(store_mode), .recall_mode(recall_mode), .strobe_gate(strobe_gate),
    .strobe_in_n(strobe_in_n), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
    .strobe_out_n(strobe_out_n), .addr_lock_n(addr_lock_n), .digit_lock_n(digit_lock_n),
    .recall_locked(recall_locked));
  rns_far_end far (.clk(clk), .clr(clr), .key_drive(key_drive), .key_val(key_val),
    .bus_out(bus_out), .bus_oe_n(bus_oe_n), .strobe_out_n(strobe_out_n),
    .bus_in(bus_in), .n_got(n_got));
  // ****************
  // helpers
  // ****************
  task automatic results;
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // key press: value held for the whole low strobe
  task automatic strobe(input logic [3:0] v, input int len);
    @(posedge clk);
    key_val <= v;
    key_drive <= 1'b1;
    strobe_in_n <= 1'b0;
    cyc(len);
    strobe_in_n <= 1'b1;
    key_drive <= 1'b0;
    cyc(40);
  endtask : strobe
  task automatic store_loc(input int i, input int n);
    logic [3:0] d;
    exp_mem[i].delete();
    chip_select <= 1'b1;
    store_mode <= 1'b1;
    strobe(4'h0, 30);
    chk("addr_lock_n", 8'h01, 8'(addr_lock_n));
    strobe(codes[i], 30);
    chk("addr_lock_n", 8'h00, 8'(addr_lock_n));
    strobe(4'h1, 6);
    repeat (n) begin
      d = 4'($urandom);
      strobe(d, 30);
      if (exp_mem[i].size() < MAX_DIGITS) exp_mem[i].push_back(d);
    end
    store_mode <= 1'b0;
    chip_select <= 1'b0;
    cyc(20);
  endtask : store_loc
  task automatic recall(input int i);
    int k;
    clr <= 1'b1;
    chip_select <= 1'b1;
    recall_mode <= 1'b1;
    cyc(40);
    clr <= 1'b0;
    recall_mode <= 1'b0;
    cyc(2);
    chk("recall_locked", 8'h01, 8'(recall_locked));
    strobe(codes[i], 30);
    if (exp_mem[i].size() > 4) chk("digit_lock_n", 8'h00, 8'(digit_lock_n));
    for (k = 0; k < 3000 && !(digit_lock_n === 1'b1 && bus_oe_n === 1'b1); k++) cyc(1);
    chip_select <= 1'b0;
    cyc(20);
    // a hung playback counts once and skips the digit checks
    if (k == 3000) begin
      n_mismatch++;
      $display("wrong value playback_done expected 1 seen 0");
      return;
    end
    chk("digit count", 8'(exp_mem[i].size()), 8'(n_got));
    for (int j = 0; j < exp_mem[i].size(); j++) begin
      chk("digit", {4'h0, exp_mem[i][j]}, {4'h0, far.got[j]});
    end
    chk("addr_lock_n", 8'h01, 8'(addr_lock_n));
  endtask : recall
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(47532));
    cyc(20);
    sys_rst <= 1'b0;
    cyc(400);
    reset_n_pin <= 1'b1;
    cyc(400);
    chk("addr_lock_n", 8'h01, 8'(addr_lock_n));
    for (int i = 0; i < 10; i++) store_loc(i, i == 0 ? 23 : i == 1 ? 0 : 1 + $urandom % 4);
    // without select nothing may latch
    store_mode <= 1'b1;
    strobe(codes[3], 30);
    chk("addr_lock_n", 8'h01, 8'(addr_lock_n));
    // select but no gate: a store may not open either
    chip_select <= 1'b1;
    strobe_gate <= 1'b0;
    strobe(codes[3], 30);
    chk("addr_lock_n", 8'h01, 8'(addr_lock_n));
    store_mode <= 1'b0;
    chip_select <= 1'b0;
    strobe_gate <= 1'b1;
    cyc(20);
    for (int i = 0; i < 10; i++) recall(i);
    store_loc(2, 0);
    recall(2);
    // pin reset held past its filter clears every length
    reset_n_pin <= 1'b0;
    cyc(400);
    reset_n_pin <= 1'b1;
    cyc(400);
    exp_mem[0].delete();
    recall(0);
    results();
  end
endmodule : tb_rns_store
